// File: include/resync_pkg.sv
package resync_pkg;
    // ***********************************************
    // Device register map
    // ***********************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] REG_SREF_FIRST = 5'h05;
    localparam logic [4:0] REG_DIV_FIRST = 5'h07;
    localparam logic [4:0] REG_SREF_SECOND = 5'h1B;
    // Carries both the divider second step and the SYSREF final step
    localparam logic [4:0] REG_SHARED = 5'h1D;
    localparam logic [4:0] REG_DIV_FINAL = 5'h1F;
    localparam int TRIGGER_BIT = 7;
    localparam logic [7:0] TRIGGER_WORD = 8'h80;

    // ***********************************************
    // Timing and widths
    // ***********************************************
    localparam int RESTART_MAX_CYCLES = 10;
    localparam int RESTART_CYCLES = 4;
    localparam int CLK_RATIO_W = 7;
    localparam int SREF_RATIO_W = 12;
    localparam int PULSE_W = 8;
    localparam logic [CLK_RATIO_W-1:0] MIN_CLK_RATIO = 7'h02;
    localparam logic [SREF_RATIO_W-1:0] MIN_SREF_RATIO = 12'h002;

    // ***********************************************
    // Host control registers (Avalon-MM)
    // ***********************************************
    localparam int CSR_ADDR_W = 4;
    localparam logic [3:0] CSR_CONTROL = 4'h0;
    localparam logic [3:0] CSR_STATUS = 4'h4;
    localparam int CTRL_START_DIV = 0;
    localparam int CTRL_START_SREF = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DIV_DONE = 1;
    localparam int STAT_SREF_DONE = 2;

    typedef enum logic [1:0] {
        DIV_IDLE, DIV_PARKED, DIV_ARMED, DIV_RESTART
    } div_step_type;
    typedef enum logic [1:0] {
        SREF_IDLE, SREF_REQUESTED, SREF_READY, SREF_BURST
    } sref_step_type;
    typedef enum logic [1:0] {
        HOST_IDLE, HOST_WRITE, HOST_POLL, HOST_CHECK
    } host_state_type;
endpackage

// File: include/resync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface resync_if;
    import resync_pkg::*;
    logic reg_write;
    logic reg_read;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;

    modport device (
        input reg_write, reg_read, reg_addr, reg_wdata,
        output reg_rdata
    );
    modport host (
        output reg_write, reg_read, reg_addr, reg_wdata,
        input reg_rdata
    );
endinterface
`default_nettype wire

// File: logic/resync_host.sv
`timescale 1ns/10ps
`default_nettype none
module resync_host
    import resync_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [CSR_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Device link
    resync_if.host link
);
    typedef struct packed {
        host_state_type state;
        logic sref_seq;
        logic [1:0] step;
        logic boot;
        logic div_done;
        logic sref_done;
        logic rd_ack;
        logic [31:0] readdata;
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
    } host_state_struct_type;

    host_state_struct_type s;
    host_state_struct_type next_s;

    function automatic logic [ADDR_W-1:0] step_addr(
        input logic sref, input logic [1:0] step);
        logic [ADDR_W-1:0] a;
        a = REG_SHARED;
        unique case (step)
            2'h0: a = sref ? REG_SREF_FIRST : REG_DIV_FIRST;
            2'h1: a = sref ? REG_SREF_SECOND : REG_SHARED;
            default: a = sref ? REG_SHARED : REG_DIV_FINAL;
        endcase
        return a;
    endfunction

    always_comb begin
        logic start_div;
        logic start_sref;
        start_div = 1'b0;
        start_sref = 1'b0;
        next_s = s;
        next_s.wr = 1'b0;
        next_s.rd = 1'b0;
        next_s.rd_ack = read && !s.rd_ack;
        if (read && !s.rd_ack) begin
            next_s.readdata = '0;
            if (address == CSR_STATUS) begin
                next_s.readdata[STAT_BUSY] = s.state != HOST_IDLE;
                next_s.readdata[STAT_DIV_DONE] = s.div_done;
                next_s.readdata[STAT_SREF_DONE] = s.sref_done;
            end
        end
        if (write && address == CSR_CONTROL) begin
            start_div = writedata[CTRL_START_DIV];
            start_sref = writedata[CTRL_START_SREF];
        end
        unique case (s.state)
            HOST_IDLE: begin
                // Divider start wins if both are asked at once
                if (s.boot || start_div || start_sref) begin
                    next_s.boot = 1'b0;
                    next_s.sref_seq = !(s.boot || start_div);
                    next_s.state = HOST_WRITE;
                    next_s.step = 2'h0;
                    if (s.boot || start_div) begin
                        next_s.div_done = 1'b0;
                    end else begin
                        next_s.sref_done = 1'b0;
                    end
                end
            end
            HOST_WRITE: begin
                next_s.wr = 1'b1;
                next_s.addr = step_addr(s.sref_seq, s.step);
                next_s.step = s.step + 2'h1;
                if (s.step == 2'h2) begin
                    next_s.state = HOST_POLL;
                end
            end
            HOST_POLL: begin
                next_s.rd = 1'b1;
                next_s.addr = step_addr(s.sref_seq, 2'h0);
                next_s.state = HOST_CHECK;
            end
            HOST_CHECK: begin
                if (!s.rd) begin
                    next_s.state = HOST_POLL;
                    if (!link.reg_rdata[TRIGGER_BIT]) begin
                        next_s.state = HOST_IDLE;
                        next_s.div_done = s.div_done || !s.sref_seq;
                        next_s.sref_done = s.sref_done || s.sref_seq;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s <= '{state: HOST_IDLE, boot: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign readdata = s.readdata;
    assign waitrequest = read && !s.rd_ack;
    assign link.reg_write = s.wr;
    assign link.reg_read = s.rd;
    assign link.reg_addr = s.addr;
    assign link.reg_wdata = TRIGGER_WORD;
endmodule
`default_nettype wire

// File: logic/resync_device.sv
`timescale 1ns/10ps
`default_nettype none
module resync_device
    import resync_pkg::*;
#(
    parameter int NUM_CLK = 3,
    parameter int NUM_REF = 4,
    parameter int RESTART_DELAY = RESTART_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register link
    resync_if.device link,
    // Configuration
    input wire logic [NUM_CLK-1:0][CLK_RATIO_W-1:0] divider_ratio,
    input wire logic [SREF_RATIO_W-1:0] sysref_ratio,
    input wire logic [PULSE_W-1:0] sysref_pulse_count,
    input wire logic sysref_override_setting,
    input wire logic [NUM_REF-1:0] sysref_enable,
    // Outputs
    output logic [NUM_CLK-1:0] divided_clock_output,
    output logic [NUM_REF-1:0] sysref_output,
    output logic divider_seq_busy,
    output logic sysref_seq_busy
);
    // ***********************************************
    // Elaboration checks
    // ***********************************************
    if (RESTART_DELAY < 1 || RESTART_DELAY > RESTART_MAX_CYCLES) begin
        $error("RESTART_DELAY must lie in 1..10");
    end
    if (NUM_CLK < 1 || NUM_REF < 1) begin
        $error("NUM_CLK and NUM_REF must be at least 1");
    end

    localparam logic [3:0] LAST_WAIT = 4'(RESTART_DELAY - 1);

    typedef struct packed {
        div_step_type div_step;
        logic [3:0] wait_cnt;
        logic div_run;
        logic [NUM_CLK-1:0][CLK_RATIO_W-1:0] div_cnt;
        logic [NUM_CLK-1:0] clk_out;
        sref_step_type sref_step;
        logic [SREF_RATIO_W-1:0] sref_cnt;
        logic [PULSE_W-1:0] pulses_left;
        logic [NUM_REF-1:0] ref_out;
        logic [DATA_W-1:0] rdata;
    } device_state_type;

    device_state_type s;
    device_state_type next_s;

    // ***********************************************
    // Helpers
    // ***********************************************
    // Ratios below two cannot toggle at this clock, so they run as two
    function automatic logic [CLK_RATIO_W-1:0] clk_ratio(
        input logic [CLK_RATIO_W-1:0] r);
        return (r < MIN_CLK_RATIO) ? MIN_CLK_RATIO : r;
    endfunction

    function automatic logic [SREF_RATIO_W-1:0] sref_ratio(
        input logic [SREF_RATIO_W-1:0] r);
        return (r < MIN_SREF_RATIO) ? MIN_SREF_RATIO : r;
    endfunction

    // Trigger bits read back the sequence progress, so they auto-clear
    function automatic logic [DATA_W-1:0] read_value(
        input logic [ADDR_W-1:0] a, input device_state_type st);
        logic flag;
        logic [DATA_W-1:0] v;
        flag = 1'b0;
        v = '0;
        unique case (a)
            REG_DIV_FIRST: flag = st.div_step != DIV_IDLE;
            REG_SREF_FIRST: flag = st.sref_step != SREF_IDLE;
            REG_SREF_SECOND:
                flag = st.sref_step inside {SREF_READY, SREF_BURST};
            REG_SHARED:
                flag = st.div_step inside {DIV_ARMED, DIV_RESTART}
                    || st.sref_step == SREF_BURST;
            REG_DIV_FINAL: flag = st.div_step == DIV_RESTART;
            default: flag = 1'b0;
        endcase
        v[TRIGGER_BIT] = flag;
        return v;
    endfunction

    // ***********************************************
    // Next state
    // ***********************************************
    always_comb begin
        logic one;
        logic hit_div_first;
        logic hit_sref_first;
        logic hit_sref_second;
        logic hit_shared;
        logic hit_div_final;
        logic div_takes_shared;
        logic [CLK_RATIO_W-1:0] r;
        logic [SREF_RATIO_W-1:0] rs;
        r = '0;
        rs = '0;
        next_s = s;
        one = link.reg_write && link.reg_wdata[TRIGGER_BIT];
        hit_div_first = one && link.reg_addr == REG_DIV_FIRST;
        hit_sref_first = one && link.reg_addr == REG_SREF_FIRST;
        hit_sref_second = one && link.reg_addr == REG_SREF_SECOND;
        hit_shared = one && link.reg_addr == REG_SHARED;
        hit_div_final = one && link.reg_addr == REG_DIV_FINAL;
        // A shared write goes to the divider only while it waits for it
        div_takes_shared = s.div_step == DIV_PARKED;

        if (link.reg_read) begin
            next_s.rdata = read_value(link.reg_addr, s);
        end

        // Divider sequence
        unique case (s.div_step)
            DIV_IDLE: begin
                if (hit_div_first) begin
                    next_s.div_step = DIV_PARKED;
                    next_s.div_run = 1'b0;
                end
            end
            DIV_PARKED: begin
                if (hit_shared) begin
                    next_s.div_step = DIV_ARMED;
                end
            end
            DIV_ARMED: begin
                if (hit_div_final) begin
                    next_s.div_step = DIV_RESTART;
                    next_s.wait_cnt = '0;
                end
            end
            DIV_RESTART: begin
                next_s.wait_cnt = s.wait_cnt + 4'h1;
                if (s.wait_cnt == LAST_WAIT) begin
                    next_s.div_step = DIV_IDLE;
                    next_s.div_run = 1'b1;
                end
            end
        endcase

        for (int i = 0; i < NUM_CLK; i++) begin
            r = clk_ratio(divider_ratio[i]);
            if (!next_s.div_run || next_s.div_step != DIV_IDLE) begin
                next_s.div_cnt[i] = '0;
                next_s.clk_out[i] = 1'b0;
            end else if (s.div_step == DIV_RESTART) begin
                // Every divider leaves restart from zero, so all rise at once
                next_s.div_cnt[i] = '0;
                next_s.clk_out[i] = 1'b1;
            end else begin
                next_s.div_cnt[i] = (s.div_cnt[i] >= r - 7'h01) ? '0
                    : s.div_cnt[i] + 7'h01;
                next_s.clk_out[i] = next_s.div_cnt[i] < (r >> 1);
            end
        end

        // SYSREF sequence
        rs = sref_ratio(sysref_ratio);
        unique case (s.sref_step)
            SREF_IDLE: begin
                if (hit_sref_first && !sysref_override_setting) begin
                    next_s.sref_step = SREF_REQUESTED;
                end
            end
            SREF_REQUESTED: begin
                if (hit_sref_second && !sysref_override_setting) begin
                    next_s.sref_step = SREF_READY;
                    next_s.sref_cnt = '0;
                    next_s.ref_out = '0;
                end
            end
            SREF_READY: begin
                if (hit_shared && !div_takes_shared
                    && !sysref_override_setting) begin
                    next_s.sref_cnt = '0;
                    next_s.pulses_left = sysref_pulse_count;
                    next_s.ref_out = sysref_enable;
                    next_s.sref_step = SREF_BURST;
                    if (sysref_pulse_count == '0) begin
                        next_s.ref_out = '0;
                        next_s.sref_step = SREF_IDLE;
                    end
                end
            end
            SREF_BURST: begin
                next_s.sref_cnt = s.sref_cnt + 12'h001;
                if (s.sref_cnt >= rs - 12'h001) begin
                    next_s.sref_cnt = '0;
                    next_s.pulses_left = s.pulses_left - 8'h01;
                end
                if (next_s.pulses_left == '0) begin
                    next_s.sref_step = SREF_IDLE;
                    next_s.ref_out = '0;
                end else begin
                    next_s.ref_out = (next_s.sref_cnt < (rs >> 1))
                        ? sysref_enable : '0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s <= '{div_step: DIV_IDLE, sref_step: SREF_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    assign divided_clock_output = s.clk_out;
    assign sysref_output = s.ref_out;
    assign divider_seq_busy = s.div_step != DIV_IDLE;
    assign sysref_seq_busy = s.sref_step != SREF_IDLE;
    assign link.reg_rdata = s.rdata;
endmodule
`default_nettype wire

// File: verif/resync_properties.sv
`timescale 1ns/10ps
`default_nettype none
module resync_properties
    import resync_pkg::*;
#(
    parameter int NUM_CLK = 3,
    parameter int NUM_REF = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register link
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Device side
    input wire logic [NUM_CLK-1:0] divided_clock_output,
    input wire logic [NUM_REF-1:0] sysref_output,
    input wire logic [NUM_REF-1:0] sysref_enable,
    input wire logic [PULSE_W-1:0] sysref_pulse_count,
    input wire logic sysref_override_setting,
    input wire logic divider_seq_busy,
    input wire logic sysref_seq_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic wr_go = reg_write && reg_wdata[TRIGGER_BIT];
    wire logic fin = wr_go && reg_addr == REG_DIV_FINAL && divider_seq_busy;
    logic [PULSE_W-1:0] pulses;

    // ***********************************************
    // Properties
    // ***********************************************
    // Counted from the step-one write so a blocked request reads zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pulses <= '0;
        end else if (reg_write && reg_addr == REG_SREF_FIRST) begin
            pulses <= '0;
        end else if ($rose(sysref_output[0])) begin
            pulses <= pulses + 8'h01;
        end
    end

    a_park_and_hold:
    assert property (wr_go && reg_addr == REG_DIV_FIRST && !divider_seq_busy
        |=> (divided_clock_output == '0) until (divided_clock_output == '1))
    else $error("clock outputs not parked low");
    a_common_rise:
    assert property (fin |=> (divided_clock_output == '0)
        until (divided_clock_output == '1))
    else $error("clock outputs did not rise together");
    a_restart_bound:
    assert property (fin |-> ##[1:10] (divided_clock_output == '1))
    else $error("dividers not restarted in time");
    a_div_first_clear:
    assert property (reg_read && reg_addr == REG_DIV_FIRST
        && !divider_seq_busy && !$past(divider_seq_busy)
        |=> !reg_rdata[TRIGGER_BIT])
    else $error("divider step one bit not cleared");
    a_sref_first_clear:
    assert property (reg_read && reg_addr == REG_SREF_FIRST
        && !sysref_seq_busy && !$past(sysref_seq_busy)
        |=> !reg_rdata[TRIGGER_BIT])
    else $error("sysref step one bit not cleared");
    a_override_block:
    assert property (sysref_override_setting && !sysref_seq_busy
        |=> !sysref_seq_busy && sysref_output == '0)
    else $error("sysref sequence ran under override");
    a_sref_ready_low:
    assert property (wr_go && reg_addr == REG_SREF_SECOND && sysref_seq_busy
        |=> sysref_output == '0)
    else $error("sysref outputs not low after step two");
    a_pulse_count:
    assert property ($fell(sysref_seq_busy) |-> ##2
        (pulses == sysref_pulse_count))
    else $error("wrong number of sysref pulses");
    a_sref_aligned:
    assert property (sysref_output
        == (sysref_enable & {NUM_REF{|sysref_output}}))
    else $error("sysref outputs not aligned or not gated");
endmodule
`default_nettype wire

// File: verif/divider_sysref_resync_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module divider_sysref_resync_ctrl_bench
    import resync_pkg::*;
;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [CSR_ADDR_W-1:0] address = '0;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata, s;
    logic waitrequest, dbusy_a, sbusy_a, dbusy_b, sbusy_b;
    logic [2:0][CLK_RATIO_W-1:0] ratio = {7'h04, 7'h03, 7'h00};
    logic [SREF_RATIO_W-1:0] sref_ratio = 12'h003;
    logic [PULSE_W-1:0] pcount = 8'h02;
    logic ovr = 1'h0;
    logic [3:0] en = 4'hB;
    logic [2:0] clk_a, clk_b;
    logic [3:0] ref_a, ref_b;
    logic prev_a = 1'h0;
    logic prev_b = 1'h0;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int rises_a = 0;
    int rises_b = 0;
    int r0, n;
    resync_if link_a();
    resync_if link_b();

    resync_host i_resync_host (.ref_clk(ref_clk), .reset(reset),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(link_a));
    resync_device i_resync_device (.ref_clk(ref_clk), .reset(reset),
        .link(link_a), .divider_ratio(ratio), .sysref_ratio(sref_ratio),
        .sysref_pulse_count(pcount), .sysref_override_setting(ovr),
        .sysref_enable(en), .divided_clock_output(clk_a),
        .sysref_output(ref_a), .divider_seq_busy(dbusy_a),
        .sysref_seq_busy(sbusy_a));
    // Second device is driven straight from the bench to break the order
    resync_device i_resync_device_b (.ref_clk(ref_clk), .reset(reset),
        .link(link_b), .divider_ratio(ratio), .sysref_ratio(sref_ratio),
        .sysref_pulse_count(pcount), .sysref_override_setting(ovr),
        .sysref_enable(en), .divided_clock_output(clk_b),
        .sysref_output(ref_b), .divider_seq_busy(dbusy_b),
        .sysref_seq_busy(sbusy_b));
    resync_properties i_resync_properties (.ref_clk(ref_clk),
        .reset(reset), .reg_write(link_a.reg_write),
        .reg_read(link_a.reg_read), .reg_addr(link_a.reg_addr),
        .reg_wdata(link_a.reg_wdata), .reg_rdata(link_a.reg_rdata),
        .divided_clock_output(clk_a), .sysref_output(ref_a),
        .sysref_enable(en), .sysref_pulse_count(pcount),
        .sysref_override_setting(ovr), .divider_seq_busy(dbusy_a),
        .sysref_seq_busy(sbusy_a));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        prev_a <= ref_a[0];
        prev_b <= ref_b[0];
        if (ref_a[0] === 1'h1 && prev_a === 1'h0) rises_a <= rises_a + 1;
        if (ref_b[0] === 1'h1 && prev_b === 1'h0) rises_b <= rises_b + 1;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ***********************************************
    // Bus tasks
    // ***********************************************
    // Request held until the edge that sees waitrequest low; data taken there
    task automatic av(input logic wr, input logic [3:0] a,
            input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge ref_clk);
        while (waitrequest !== 1'h0) begin
            @(posedge ref_clk);
        end
        s = readdata;
        write <= 1'h0;
        read <= 1'h0;
    endtask

    task automatic idle_a();
        for (int i = 0; i < 400; i++) begin
            av(1'h0, CSR_STATUS, '0);
            if (s[STAT_BUSY] === 1'h0) break;
        end
    endtask

    task automatic lw(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        link_b.reg_write <= 1'h1;
        link_b.reg_addr <= a;
        link_b.reg_wdata <= d;
        @(posedge ref_clk);
        link_b.reg_write <= 1'h0;
        link_b.reg_wdata <= ~d;
        #1;
    endtask

    task automatic lr(input logic [4:0] a, input logic e);
        @(posedge ref_clk);
        link_b.reg_read <= 1'h1;
        link_b.reg_addr <= a;
        @(posedge ref_clk);
        link_b.reg_read <= 1'h0;
        @(posedge ref_clk);
        check("trigger bit", {31'h0, e},
            {31'h0, link_b.reg_rdata[TRIGGER_BIT]});
    endtask

    task automatic div_seq();
        lw(REG_DIV_FIRST, TRIGGER_WORD);
        lr(REG_DIV_FIRST, 1'h1);
        check("parked", 32'h8, {dbusy_b, clk_b});
        lw(REG_SHARED, TRIGGER_WORD);
        lr(REG_SHARED, 1'h1);
        lw(REG_DIV_FINAL, TRIGGER_WORD);
        n = 0;
        while (clk_b === 3'h0 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("restart cycles", RESTART_CYCLES, n);
        check("common rise", 32'h7, clk_b);
        lr(REG_SHARED, 1'h0);
        lr(REG_DIV_FINAL, 1'h0);
        lr(REG_DIV_FIRST, 1'h0);
    endtask

    // ***********************************************
    // Scenarios
    // ***********************************************
    initial begin
        link_b.reg_write = 1'h0;
        link_b.reg_read = 1'h0;
        link_b.reg_addr = '0;
        link_b.reg_wdata = '0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'h0;
        idle_a();
        check("boot status", 32'h2, s);
        r0 = rises_a;
        av(1'h1, CSR_CONTROL, 32'h2);
        idle_a();
        check("sysref status", 32'h6, s);
        check("pulses a", pcount, rises_a - r0);
        r0 = rises_a;
        av(1'h1, CSR_CONTROL, 32'h1);
        av(1'h1, CSR_CONTROL, 32'h2);
        idle_a();
        check("start while busy", 32'h0, rises_a - r0);
        ovr <= 1'h1;
        av(1'h1, CSR_CONTROL, 32'h2);
        idle_a();
        check("override a", 32'h0, rises_a - r0);
        ovr <= 1'h0;
        av(1'h1, 4'hC, 32'h3);
        av(1'h0, 4'h8, '0);
        check("unmapped read", 32'h0, s);
        av(1'h0, CSR_STATUS, '0);
        check("unmapped write", 32'h0, s & 32'h1);
        div_seq();
        lw(REG_DIV_FIRST, 8'h00);
        check("zero write", 32'h0, dbusy_b);
        lw(REG_DIV_FINAL, TRIGGER_WORD);
        lw(REG_SHARED, TRIGGER_WORD);
        check("out of order", 32'h0, {dbusy_b, sbusy_b});
        div_seq();
        ovr <= 1'h1;
        pcount <= 8'hFF;
        lw(REG_SREF_FIRST, TRIGGER_WORD);
        check("override b", 32'h0, sbusy_b);
        ovr <= 1'h0;
        lw(REG_SREF_FIRST, TRIGGER_WORD);
        lw(REG_SREF_SECOND, 8'h00);
        lr(REG_SREF_SECOND, 1'h0);
        lw(REG_SREF_SECOND, TRIGGER_WORD);
        lr(REG_SREF_SECOND, 1'h1);
        check("ready low", 32'h0, ref_b);
        r0 = rises_b;
        lw(REG_SHARED, TRIGGER_WORD);
        for (n = 0; n < 3000 && sbusy_b !== 1'h0; n++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1;
        check("pulses b", pcount, rises_b - r0);
        lr(REG_SREF_FIRST, 1'h0);
        lr(REG_SREF_SECOND, 1'h0);
        lr(REG_SHARED, 1'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
